// *** rtl/synth_cfg_pkg.sv ***
// Package: register map, reset values, field layouts and carriers of the synthesizer config group
package synth_cfg_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] STAMP_INPUT_CONTROL_OFS = 8'h3b;
   localparam logic [7:0] REF_CLOCK_OUTPUT_CONTROL_OFS = 8'h3c;
   localparam logic [7:0] SYNTH_FEEDBACK_DIV_FIRST_SECOND_OFS = 8'h3d;
   localparam logic [7:0] SYNTH_FEEDBACK_DIV_THIRD_OFS = 8'h3e;
   localparam logic [7:0] SYNTH_OSCILLATOR_BIAS_OFS = 8'h3f;
   localparam logic [7:0] LANE_PREEMPHASIS_CONTROL_OFS = 8'h48;

   // ==========================================================
   // Reset values
   localparam logic [7:0] STAMP_INPUT_CONTROL_RST = 8'h00;
   localparam logic [7:0] REF_CLOCK_OUTPUT_CONTROL_RST = 8'h01;
   localparam logic [7:0] SYNTH_FEEDBACK_DIV_FIRST_SECOND_RST = 8'h00;
   localparam logic [7:0] SYNTH_FEEDBACK_DIV_THIRD_RST = 8'h20;
   localparam logic [7:0] SYNTH_OSCILLATOR_BIAS_RST = 8'h4f;
   localparam logic [7:0] LANE_PREEMPHASIS_CONTROL_RST = 8'h00;

   // ==========================================================
   // Field positions
   localparam int STAMP_RECEIVER_ON_BIT = 0;
   localparam int STAMP_LOWV_TERM_SEL_BIT = 1;
   localparam int REF_OUT_ON_BIT = 0;
   localparam int FIRST_DIV_LSB = 0;
   localparam int SECOND_DIV_LSB = 2;
   localparam int THIRD_DIV_LSB = 0;
   localparam int THIRD_DIV_W = 6;
   localparam int OSC_BIAS_LSB = 0;
   localparam int OSC_BIAS_W = 7;
   localparam int PREEMPH_LSB = 0;
   localparam int PREEMPH_W = 4;
   localparam int NUM_LANES = 8;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
   } reg_rsp_type;

   // ==========================================================
   // Divider code decode; reserved code 3 behaves like code 0
   function automatic logic [2:0] first_div_ratio(input logic [1:0] code);
      case (code)
         2'h1: first_div_ratio = 3'h4;
         2'h2: first_div_ratio = 3'h3;
         default: first_div_ratio = 3'h5;
      endcase
   endfunction : first_div_ratio

   function automatic logic [2:0] second_div_ratio(input logic [1:0] code);
      case (code)
         2'h1: second_div_ratio = 3'h2;
         2'h2: second_div_ratio = 3'h4;
         default: second_div_ratio = 3'h1;
      endcase
   endfunction : second_div_ratio

endpackage : synth_cfg_pkg

// *** rtl/synth_feedback_chain.sv ***
// Feedback divider chain of the clock synthesizer, driven by oscillator enable pulses
module synth_feedback_chain (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Control
   input wire logic i_hold,
   input wire logic i_osc_tick,
   input wire logic [1:0] i_first_code,
   input wire logic [1:0] i_second_code,
   input wire logic [5:0] i_third_value,
   // Divided pulses
   output logic o_sample_tick,
   output logic o_pfd_tick
);
   logic [2:0] first_cnt_r;
   logic [2:0] second_cnt_r;
   logic [5:0] third_cnt_r;
   logic first_out;
   logic second_out;
   logic [2:0] first_ratio;
   logic [2:0] second_ratio;

   assign first_ratio = synth_cfg_pkg::first_div_ratio(i_first_code);
   assign second_ratio = synth_cfg_pkg::second_div_ratio(i_second_code);
   // First divider output is the only input of the second one
   assign first_out = i_osc_tick && (first_cnt_r >= first_ratio - 3'h1);
   assign second_out = first_out && (second_cnt_r >= second_ratio - 3'h1);

   // ==========================================================
   // First divider
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         first_cnt_r <= 3'h0;
      end else if (i_hold) begin
         first_cnt_r <= 3'h0;
      end else if (i_osc_tick) begin
         first_cnt_r <= first_out ? 3'h0 : first_cnt_r + 3'h1;
      end
   end

   // ==========================================================
   // Second divider, output is the sampling clock
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         second_cnt_r <= 3'h0;
         o_sample_tick <= 1'b0;
      end else if (i_hold) begin
         second_cnt_r <= 3'h0;
         o_sample_tick <= 1'b0;
      end else begin
         o_sample_tick <= second_out;
         if (first_out) begin
            second_cnt_r <= second_out ? 3'h0 : second_cnt_r + 3'h1;
         end
      end
   end

   // ==========================================================
   // Third divider: sampling clock divided by the field value; zero gives no pulses
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         third_cnt_r <= 6'h00;
         o_pfd_tick <= 1'b0;
      end else if (i_hold) begin
         third_cnt_r <= 6'h00;
         o_pfd_tick <= 1'b0;
      end else begin
         o_pfd_tick <= 1'b0;
         if (second_out && i_third_value != 6'h00) begin
            if (third_cnt_r >= i_third_value - 6'h01) begin
               third_cnt_r <= 6'h00;
               o_pfd_tick <= 1'b1;
            end else begin
               third_cnt_r <= third_cnt_r + 6'h01;
            end
         end
      end
   end

endmodule : synth_feedback_chain

// *** rtl/pll_timestamp_cfg_regs.sv ***
// Configuration registers for timestamp input, reference output, synthesizer and lanes
// ==========================================================
// Overview of operation
// - Bit 1 selects low-voltage termination, no self-bias
// - Bit 0 enables timestamp receiver, resets off
// - Reference output on only when enabled and synth on
// - Reference output enable resets to one
// - Second divider code: 1, 2, 4
// - First divider code: 5, 4, 3
// - First divider feeds second; second gives sample clock
// - Third divider divides sample clock, resets 32
// - One pre-emphasis setting for all eight lanes
module pll_timestamp_cfg_regs (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_resetn,
   // Register port from the serial control interface
   input synth_cfg_pkg::reg_req_type i_reg_req,
   output synth_cfg_pkg::reg_rsp_type o_reg_rsp,
   // Synthesizer status from neighbouring logic
   input wire logic i_synth_enable,
   input wire logic i_synth_reset_bit,
   input wire logic i_osc_tick,
   // Timestamp input receiver
   output logic o_stamp_receiver_on,
   output logic o_stamp_input_lowv_term_sel,
   output logic o_stamp_self_bias_on,
   // Reference output and synthesizer
   output logic o_synth_ref_output_on,
   output logic [6:0] o_osc_bias_level,
   output logic o_sample_tick,
   output logic o_pfd_tick,
   // Serializer lanes
   output logic [synth_cfg_pkg::NUM_LANES*synth_cfg_pkg::PREEMPH_W-1:0] o_lane_preemphasis
);
   logic rst_meta_r;
   logic rst_n;
   logic [7:0] stamp_ctrl_r;
   logic [7:0] ref_ctrl_r;
   logic [7:0] div12_r;
   logic [7:0] div3_r;
   logic [7:0] bias_r;
   logic [7:0] preemph_r;
   logic [7:0] rdata_nxt;
   logic wr;
   logic wr_stamp;
   logic wr_ref;
   logic wr_div12;
   logic wr_div3;
   logic wr_bias;
   logic wr_preemph;

   // ==========================================================
   // Reset release through two flip-flops
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   assign wr = i_reg_req.wr;
   // One strobe per register; an unmapped address raises none, so the write is dropped
   assign wr_stamp = wr && (i_reg_req.addr == synth_cfg_pkg::STAMP_INPUT_CONTROL_OFS);
   assign wr_ref = wr && (i_reg_req.addr == synth_cfg_pkg::REF_CLOCK_OUTPUT_CONTROL_OFS);
   assign wr_div12 = wr && (i_reg_req.addr == synth_cfg_pkg::SYNTH_FEEDBACK_DIV_FIRST_SECOND_OFS);
   assign wr_div3 = wr && (i_reg_req.addr == synth_cfg_pkg::SYNTH_FEEDBACK_DIV_THIRD_OFS);
   assign wr_bias = wr && (i_reg_req.addr == synth_cfg_pkg::SYNTH_OSCILLATOR_BIAS_OFS);
   assign wr_preemph = wr && (i_reg_req.addr == synth_cfg_pkg::LANE_PREEMPHASIS_CONTROL_OFS);

   // ==========================================================
   // Timestamp input control; all bits stored so reserved bits read back too
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         stamp_ctrl_r <= synth_cfg_pkg::STAMP_INPUT_CONTROL_RST;
      end else if (wr_stamp) begin
         stamp_ctrl_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // Reference output control
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_ctrl_r <= synth_cfg_pkg::REF_CLOCK_OUTPUT_CONTROL_RST;
      end else if (wr_ref) begin
         ref_ctrl_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // First and second divider codes
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         div12_r <= synth_cfg_pkg::SYNTH_FEEDBACK_DIV_FIRST_SECOND_RST;
      end else if (wr_div12) begin
         div12_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // Third divider value
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         div3_r <= synth_cfg_pkg::SYNTH_FEEDBACK_DIV_THIRD_RST;
      end else if (wr_div3) begin
         div3_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // Oscillator bias
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         bias_r <= synth_cfg_pkg::SYNTH_OSCILLATOR_BIAS_RST;
      end else if (wr_bias) begin
         bias_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // Lane pre-emphasis
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         preemph_r <= synth_cfg_pkg::LANE_PREEMPHASIS_CONTROL_RST;
      end else if (wr_preemph) begin
         preemph_r <= i_reg_req.wdata;
      end
   end

   // ==========================================================
   // Read decode; addresses outside this group answer zero
   always_comb begin
      case (i_reg_req.addr)
         synth_cfg_pkg::STAMP_INPUT_CONTROL_OFS: rdata_nxt = stamp_ctrl_r;
         synth_cfg_pkg::REF_CLOCK_OUTPUT_CONTROL_OFS: rdata_nxt = ref_ctrl_r;
         synth_cfg_pkg::SYNTH_FEEDBACK_DIV_FIRST_SECOND_OFS: rdata_nxt = div12_r;
         synth_cfg_pkg::SYNTH_FEEDBACK_DIV_THIRD_OFS: rdata_nxt = div3_r;
         synth_cfg_pkg::SYNTH_OSCILLATOR_BIAS_OFS: rdata_nxt = bias_r;
         synth_cfg_pkg::LANE_PREEMPHASIS_CONTROL_OFS: rdata_nxt = preemph_r;
         default: rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_rsp <= '0;
      end else begin
         o_reg_rsp.valid <= i_reg_req.rd;
         o_reg_rsp.rdata <= i_reg_req.rd ? rdata_nxt : 8'h00;
      end
   end

   // ==========================================================
   // Timestamp receiver controls
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_stamp_receiver_on <= 1'b0;
         o_stamp_input_lowv_term_sel <= 1'b0;
         o_stamp_self_bias_on <= 1'b1;
      end else begin
         o_stamp_receiver_on <= stamp_ctrl_r[synth_cfg_pkg::STAMP_RECEIVER_ON_BIT];
         o_stamp_input_lowv_term_sel <=
            stamp_ctrl_r[synth_cfg_pkg::STAMP_LOWV_TERM_SEL_BIT];
         // Grounded termination and common-mode self-bias would fight each other
         o_stamp_self_bias_on <=
            !stamp_ctrl_r[synth_cfg_pkg::STAMP_LOWV_TERM_SEL_BIT];
      end
   end

   // ==========================================================
   // Reference output, bias and lane pre-emphasis
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_synth_ref_output_on <= 1'b0;
      end else begin
         // Comes up by itself because the control clock may be derived from it
         o_synth_ref_output_on <= ref_ctrl_r[synth_cfg_pkg::REF_OUT_ON_BIT]
            && i_synth_enable;
      end
   end

   // Bias level passes through untouched; software chooses the value to load
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_osc_bias_level <= synth_cfg_pkg::SYNTH_OSCILLATOR_BIAS_RST[6:0];
      end else begin
         o_osc_bias_level <= bias_r[synth_cfg_pkg::OSC_BIAS_LSB +: synth_cfg_pkg::OSC_BIAS_W];
      end
   end

   // One setting fanned out to every lane, so lanes can never disagree
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_lane_preemphasis <= '0;
      end else begin
         o_lane_preemphasis <= {synth_cfg_pkg::NUM_LANES{
            preemph_r[synth_cfg_pkg::PREEMPH_LSB +: synth_cfg_pkg::PREEMPH_W]}};
      end
   end

   // ==========================================================
   // Feedback chain; relies on software holding it in reset while codes change
   synth_feedback_chain u_chain (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_hold(i_synth_reset_bit || !i_synth_enable),
      .i_osc_tick(i_osc_tick),
      .i_first_code(div12_r[synth_cfg_pkg::FIRST_DIV_LSB +: 2]),
      .i_second_code(div12_r[synth_cfg_pkg::SECOND_DIV_LSB +: 2]),
      .i_third_value(
         div3_r[synth_cfg_pkg::THIRD_DIV_LSB +: synth_cfg_pkg::THIRD_DIV_W]),
      .o_sample_tick(o_sample_tick),
      .o_pfd_tick(o_pfd_tick)
   );

endmodule : pll_timestamp_cfg_regs

// *** verif/pll_timestamp_cfg_regs_checker.sv ***
// Concurrent checks on the ports of the synthesizer configuration register group
module pll_timestamp_cfg_regs_checker (
   // Clock, reset and requests
   input wire logic i_mclk,
   input wire logic i_resetn,
   input synth_cfg_pkg::reg_req_type i_reg_req,
   input synth_cfg_pkg::reg_rsp_type o_reg_rsp,
   input wire logic i_synth_enable,
   input wire logic i_synth_reset_bit,
   input wire logic i_osc_tick,
   // Observed outputs
   input wire logic o_stamp_receiver_on,
   input wire logic o_stamp_input_lowv_term_sel,
   input wire logic o_stamp_self_bias_on,
   input wire logic o_synth_ref_output_on,
   input wire logic [6:0] o_osc_bias_level,
   input wire logic o_sample_tick,
   input wire logic o_pfd_tick,
   input wire logic [synth_cfg_pkg::NUM_LANES*synth_cfg_pkg::PREEMPH_W-1:0] o_lane_preemphasis
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // ==========================================================
   // Register port
   property p_read_answer; i_reg_req.rd |=> o_reg_rsp.valid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_no_stray_valid; !i_reg_req.rd |=> !o_reg_rsp.valid; endproperty
   a_no_stray_valid: assert property (p_no_stray_valid) else $error("stray valid");
   // ==========================================================
   // Field outputs follow writes two cycles on
   property p_stamp_on;
      i_reg_req.wr && i_reg_req.addr == synth_cfg_pkg::STAMP_INPUT_CONTROL_OFS
         |-> ##2 o_stamp_receiver_on == $past(i_reg_req.wdata[0], 2);
   endproperty
   a_stamp_on: assert property (p_stamp_on) else $error("receiver enable wrong");
   property p_term_sel;
      i_reg_req.wr && i_reg_req.addr == synth_cfg_pkg::STAMP_INPUT_CONTROL_OFS
         |-> ##2 o_stamp_input_lowv_term_sel == $past(i_reg_req.wdata[1], 2)
         && o_stamp_self_bias_on != o_stamp_input_lowv_term_sel;
   endproperty
   a_term_sel: assert property (p_term_sel) else $error("termination mode wrong");
   property p_bias;
      i_reg_req.wr && i_reg_req.addr == synth_cfg_pkg::SYNTH_OSCILLATOR_BIAS_OFS
         |-> ##2 o_osc_bias_level == $past(i_reg_req.wdata[6:0], 2);
   endproperty
   a_bias: assert property (p_bias) else $error("bias level wrong");
   property p_lanes;
      i_reg_req.wr && i_reg_req.addr == synth_cfg_pkg::LANE_PREEMPHASIS_CONTROL_OFS
         |-> ##2 o_lane_preemphasis == {8{$past(i_reg_req.wdata[3:0], 2)}};
   endproperty
   a_lanes: assert property (p_lanes) else $error("lane setting wrong");
   property p_ref_needs_synth; o_synth_ref_output_on |-> $past(i_synth_enable); endproperty
   a_ref_needs_synth: assert property (p_ref_needs_synth) else $error("stray ref out");
   // ==========================================================
   // Divider chain
   property p_chain_hold; i_synth_reset_bit || !i_synth_enable |=> !o_sample_tick; endproperty
   a_chain_hold: assert property (p_chain_hold) else $error("chain not held");
   property p_sample_cause; o_sample_tick |-> $past(i_osc_tick); endproperty
   a_sample_cause: assert property (p_sample_cause) else $error("sample w/o tick");
   property p_pfd_on_sample; o_pfd_tick |-> o_sample_tick; endproperty
   a_pfd_on_sample: assert property (p_pfd_on_sample) else $error("pfd off sample");
   c_read: cover property (o_reg_rsp.valid);
   c_pfd: cover property (o_pfd_tick);
   c_ref_off: cover property (o_synth_ref_output_on ##1 !o_synth_ref_output_on);
endmodule : pll_timestamp_cfg_regs_checker

bind pll_timestamp_cfg_regs pll_timestamp_cfg_regs_checker chk_u (.i_mclk, .i_resetn, .i_reg_req,
   .o_reg_rsp, .i_synth_enable, .i_synth_reset_bit, .i_osc_tick, .o_stamp_receiver_on,
   .o_stamp_input_lowv_term_sel, .o_stamp_self_bias_on, .o_synth_ref_output_on,
   .o_osc_bias_level, .o_sample_tick, .o_pfd_tick, .o_lane_preemphasis);

// *** verif/pll_timestamp_cfg_regs_test.sv ***
// Self-checking bench of the synthesizer configuration register group
module pll_timestamp_cfg_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Signals and tables
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   synth_cfg_pkg::reg_req_type req = '0;
   synth_cfg_pkg::reg_rsp_type rsp;
   logic en = 1'b1;
   logic srst = 1'b0;
   logic tick = 1'b0;
   logic rx_on, term_sel, self_bias, ref_on, samp, pfd;
   logic [6:0] bias;
   logic [31:0] lanes;
   logic [7:0] exp_q[$];
   logic [7:0] shadow[6];
   int failures = 0;
   int check_count = 0;
   int n;
   localparam logic [7:0] OFS[6] = '{8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h48};
   localparam logic [7:0] RST[6] = '{8'h00, 8'h01, 8'h00, 8'h20, 8'h4f, 8'h00};
   // Reserved bits are always written as zero
   localparam logic [7:0] MASK[6] = '{8'h03, 8'h01, 8'h0f, 8'h3f, 8'h7f, 8'h0f};
   always #50 i_mclk = ~i_mclk;
   pll_timestamp_cfg_regs dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_req(req),
      .o_reg_rsp(rsp), .i_synth_enable(en), .i_synth_reset_bit(srst), .i_osc_tick(tick),
      .o_stamp_receiver_on(rx_on), .o_stamp_input_lowv_term_sel(term_sel),
      .o_stamp_self_bias_on(self_bias), .o_synth_ref_output_on(ref_on), .o_osc_bias_level(bias),
      .o_sample_tick(samp), .o_pfd_tick(pfd), .o_lane_preemphasis(lanes));
   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      #10;
      req = '{w, r, a, d};
   endtask : op
   task automatic idle(input int cycles);
      op(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (cycles) @(posedge i_mclk);
      #10;
   endtask : idle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      op(1'b0, 1'b1, a, 8'h00);
   endtask : rd
   // Counts cycles until the next pulse; called twice it gives the pulse period
   task automatic meas(input logic use_pfd, output int cnt);
      cnt = 0;
      do begin
         @(negedge i_mclk);
         cnt++;
      end while ((use_pfd ? pfd : samp) !== 1'b1 && cnt < 500);
   endtask : meas
   function automatic int vr(input logic [1:0] c);
      return (c == 2'h1) ? 4 : (c == 2'h2) ? 3 : 5;
   endfunction : vr
   function automatic int pr(input logic [1:0] c);
      return (c == 2'h1) ? 2 : (c == 2'h2) ? 4 : 1;
   endfunction : pr
   task automatic reset_test();
      i_resetn = 1'b0;
      repeat (20) @(posedge i_mclk);
      #10;
      i_resetn = 1'b1;
      repeat (3) @(posedge i_mclk);
      idle(1);
      check({rx_on, term_sel, self_bias}, 32'h1);
      check(ref_on, 32'h1);
      check(bias, 32'h4f);
      check(lanes, 32'h0);
      for (int i = 0; i < 6; i++) rd(OFS[i], RST[i]);
      idle(2);
      $display("test done: reset values");
   endtask : reset_test
   task automatic close_out();
      $display("checks=%0d failures=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // ==========================================================
   // Read answers are matched against notes taken when the read was issued
   always @(negedge i_mclk) begin
      if (rsp.valid === 1'b1) begin
         if (exp_q.size() == 0) check({24'h0, rsp.rdata}, 32'hffffffff);
         else check(rsp.rdata, exp_q.pop_front());
      end
   end
   initial begin
      #2_000_000;
      failures++;
      close_out();
   end
   initial begin
      void'($urandom(32'h397b707e));
      reset_test();
      srst = 1'b1;
      for (int i = 0; i < 6; i++) begin
         shadow[i] = 8'($urandom) & MASK[i];
         op(1'b1, 1'b0, OFS[i], shadow[i]);
      end
      op(1'b1, 1'b0, 8'h47, 8'h00);
      rd(8'h47, 8'h00);
      exp_q.push_back(shadow[0]);
      op(1'b1, 1'b1, OFS[0], shadow[0] ^ 8'h03);
      shadow[0] = shadow[0] ^ 8'h03;
      for (int i = 0; i < 6; i++) rd(OFS[i], shadow[i]);
      idle(3);
      check(lanes, {8{shadow[5][3:0]}});
      check({bias, ref_on}, {shadow[4][6:0], shadow[1][0]});
      $display("test done: read back");
      reset_test();
      op(1'b1, 1'b0, OFS[4], 8'h4a);
      for (int c = 0; c < 4; c++) begin
         op(1'b1, 1'b0, OFS[0], 8'(c));
         op(1'b1, 1'b0, OFS[1], 8'(c & 1));
         en = c[1];
         idle(3);
         check({rx_on, term_sel, self_bias}, {c[0], c[1], !c[1]});
         check(ref_on, c[0] & c[1]);
      end
      check(bias, 32'h4a);
      $display("test done: stamp and reference output");
      en = 1'b1;
      tick = 1'b1;
      for (int c = 0; c < 16; c++) begin
         @(posedge i_mclk);
         #10;
         srst = 1'b1;
         op(1'b1, 1'b0, OFS[2], 8'(c));
         op(1'b1, 1'b0, OFS[3], 8'h03);
         idle(1);
         srst = 1'b0;
         meas(1'b0, n);
         meas(1'b0, n);
         check(n, vr(2'(c)) * pr(2'(c >> 2)));
         meas(1'b1, n);
         meas(1'b1, n);
         check(n, 3 * vr(2'(c)) * pr(2'(c >> 2)));
      end
      $display("test done: divider chain");
      check(exp_q.size(), 32'h0);
      close_out();
   end
endmodule : pll_timestamp_cfg_regs_test
